// >>> tcr_consts.vh
/*
 Register addresses, bit positions, reset values and the unavailable prescaler code of the two-channel timer.
 Assumes an 8-bit register port with a 3-bit address; included by the timer top module.
*/
`ifndef TCR_CONSTS_VH
`define TCR_CONSTS_VH

// Register addresses on the plain register port.
`define TCR_ADDR_TSTAT  3'h0
`define TCR_ADDR_CNTH   3'h1
`define TCR_ADDR_CNTL   3'h2
`define TCR_ADDR_WRAPH  3'h3
`define TCR_ADDR_WRAPL  3'h4
`define TCR_ADDR_CH0SC  3'h5
`define TCR_ADDR_CH1SC  3'h6
`define TCR_ADDR_CH0VH  3'h7

// Timer status and control bit positions.
`define TCR_TS_OVF      7
`define TCR_TS_OVIE     6
`define TCR_TS_HALT     5
`define TCR_TS_CLR      4
`define TCR_TS_PS_MSB   2

// Channel status and control bit positions.
`define TCR_CS_FLAG     7
`define TCR_CS_IE       6
`define TCR_CS_BUF      5
`define TCR_CS_UNBUF    4
`define TCR_CS_ELH      3
`define TCR_CS_ELL      2
`define TCR_CS_TOV      1
`define TCR_CS_MAX      0

// Reset values.
`define TCR_TSTAT_RST   8'h20
`define TCR_WRAP_RST    16'hFFFF
`define TCR_CHVAL_RST   16'hFFFF

// Unavailable prescaler code.
`define TCR_PS_NONE     3'h7

`endif

// >>> tcr_timer.v
/*
 Two-channel 16-bit timer: counter with prescaler and wrap value, two capture/compare channels.
 Assumes one 250 MHz clock, a register master on the same clock and asynchronous channel pins.
 Channel compare values are parameters here; their registers live outside this block.
*/
// The plain strobed port and the register offsets are this design's own decisions.
// Functional notes
// [R01] Counter equal to wrap value sets overflow flag, next timer tick restarts at zero.
// [R02] Overflow flag clears only by zero-write after a read that saw it set.
// [R03] Overflow interrupt request is flag and overflow enable; reset clears enable.
// [R04] Halt bit freezes the counter; reset sets halt.
// [R05] While halted, input captures are suppressed.
// [R06] Writing one to clear bit zeroes counter and prescaler; bit reads zero.
// [R07] Halt and clear written together leave counter stopped at zero.
// [R08] Prescale code selects bus clock divide by 1 to 64; code 111 unavailable.
// [R09] Reading count high latches the low byte until the low byte is read.
// [R10] After wrap high write, overflow flag is suppressed until wrap low write.
// [R11] Software resets the counter before writing the wrap registers.
// [R12] Channel flag set by active pin edge in capture or match in compare.
// [R13] Channel flag clears only by zero-write after a read showing it set.
// [R14] Channel interrupt request is channel flag and channel enable.
// [R15] Buffered bit on channel 0 only; disables channel 1 and frees its pin.
// [R16] Edge bits zero: unbuffered bit picks preset level, one low, zero high.
// [R17] Edge bits zero disconnect the channel from its pin.
// [R18] Capture codes: 01 rising, 10 falling, 11 both edges.
// [R19] Compare codes: 01 toggle, 10 clear, 11 set; 00 is software compare.
// [R20] Software halts and clears the counter before changing channel mode bits.
// [R21] Each pin capture or compare independently; only channel 0 buffers.
// [R22] Toggle-on-overflow toggles the pin on overflow; overflow beats a match.
// [R23] Full-duty bit with toggle-on-overflow forces full duty from the next period.
// [R24] Interrupt lines follow flag and enable continuously.
`include "tcr_consts.vh"
module tcr_timer #(
   parameter [15:0] CH0_VALUE = `TCR_CHVAL_RST,
   parameter [15:0] CH1_VALUE = `TCR_CHVAL_RST
)(
   // Clock and reset.
   input  wire       clk_i,
   input  wire       rst_n_i,
   // Register port.
   input  wire [2:0] addr_i,
   input  wire [7:0] wdata_i,
   input  wire       wr_i,
   input  wire       rd_i,
   output reg  [7:0] rdata_o,
   // Channel pins, split into input, output and enable.
   input  wire [1:0] chan_pin_i,
   output reg  [1:0] chan_pin_o,
   output reg  [1:0] chan_pin_oe_o,
   // Interrupt requests.
   output reg        ovf_irq_o,
   output reg  [1:0] chan_irq_o
);

   // Timer status and control state.
   reg        overflow_flag;
   reg        overflow_irq_enable;
   reg        counter_halt;
   reg  [2:0] prescale_select;
   reg        ovf_armed;
   // Counter, prescaler, latch and wrap value.
   reg [15:0] count;
   reg  [5:0] prescaler;
   reg  [7:0] low_latch;
   reg        low_latched;
   reg [15:0] wrap_value;
   reg  [7:0] wrap_high_hold;
   reg        wrap_pending;
   // Channel state.
   reg  [1:0] channel_event_flag;
   reg  [1:0] channel_irq_enable;
   reg        channel0_buffered_select;
   reg  [1:0] unbuffered_mode_select;
   reg  [1:0] edge_level_high;
   reg  [1:0] edge_level_low;
   reg  [1:0] overflow_toggle_enable;
   reg  [1:0] full_duty_force;
   reg  [1:0] full_duty_active;
   reg  [1:0] chan_armed;
   reg  [1:0] pin_level;
   // Pin synchroniser and edge history.
   reg  [1:0] pin_meta;
   reg  [1:0] pin_sync;
   reg  [1:0] pin_prev;

   // Prescaler divide mask for a select code.
   function [5:0] tcr_div_mask;
      input [2:0] sel;
      begin
         tcr_div_mask = (6'h01 << sel) - 6'h01;
      end
   endfunction

   // Register decode strobes.
   wire wr_tstat = wr_i && (addr_i == `TCR_ADDR_TSTAT);
   wire rd_tstat = rd_i && (addr_i == `TCR_ADDR_TSTAT);
   wire wr_wraph = wr_i && (addr_i == `TCR_ADDR_WRAPH);
   wire wr_wrapl = wr_i && (addr_i == `TCR_ADDR_WRAPL);
   wire rd_cnth  = rd_i && (addr_i == `TCR_ADDR_CNTH);
   wire rd_cntl  = rd_i && (addr_i == `TCR_ADDR_CNTL);
   wire [1:0] wr_csc;
   wire [1:0] rd_csc;
   assign wr_csc[0] = wr_i && (addr_i == `TCR_ADDR_CH0SC);
   assign rd_csc[0] = rd_i && (addr_i == `TCR_ADDR_CH0SC);
   assign wr_csc[1] = wr_i && (addr_i == `TCR_ADDR_CH1SC) && !channel0_buffered_select; // R15
   assign rd_csc[1] = rd_i && (addr_i == `TCR_ADDR_CH1SC) && !channel0_buffered_select;

   // Timer tick from the prescaler; code 111 never ticks.
   wire tick = !counter_halt && (prescale_select != `TCR_PS_NONE) &&
               ((prescaler & tcr_div_mask(prescale_select)) == tcr_div_mask(prescale_select)); // R08
   wire at_wrap   = (count == wrap_value);
   wire ovf_event = tick && at_wrap;
   wire clr_write = wr_tstat && wdata_i[`TCR_TS_CLR];

   // Counter and prescaler.
   always @(posedge clk_i or negedge rst_n_i)
   begin
      if (!rst_n_i)
      begin
         count     <= 16'h0000;
         prescaler <= 6'h00;
      end
      else if (clr_write)
      begin
         count     <= 16'h0000; // R06 R07
         prescaler <= 6'h00;
      end
      else if (!counter_halt) // R04
      begin
         prescaler <= prescaler + 6'h01;
         if (tick)
            count <= at_wrap ? 16'h0000 : count + 16'h0001; // R01
      end
   end

   // Timer status and control register with the two-step overflow clear.
   always @(posedge clk_i or negedge rst_n_i)
   begin
      if (!rst_n_i)
      begin
         overflow_flag       <= 1'b0;
         overflow_irq_enable <= 1'b0;
         counter_halt        <= 1'b1;
         prescale_select     <= 3'h0;
         ovf_armed           <= 1'b0;
      end
      else
      begin
         if (ovf_event && !wrap_pending)
         begin
            overflow_flag <= 1'b1; // R01 R10
            ovf_armed     <= 1'b0;
         end
         else if (wr_tstat && ovf_armed && !wdata_i[`TCR_TS_OVF])
         begin
            overflow_flag <= 1'b0; // R02
            ovf_armed     <= 1'b0;
         end
         else if (rd_tstat && overflow_flag)
            ovf_armed <= 1'b1;
         if (wr_tstat)
         begin
            overflow_irq_enable <= wdata_i[`TCR_TS_OVIE];
            counter_halt        <= wdata_i[`TCR_TS_HALT]; // R04 R07
            prescale_select     <= wdata_i[`TCR_TS_PS_MSB:0];
         end
      end
   end

   // Wrap value registers; high byte is held until the low byte lands.
   always @(posedge clk_i or negedge rst_n_i)
   begin
      if (!rst_n_i)
      begin
         wrap_value     <= `TCR_WRAP_RST;
         wrap_high_hold <= 8'h00;
         wrap_pending   <= 1'b0;
      end
      else if (wr_wraph)
      begin
         wrap_high_hold <= wdata_i;
         wrap_pending   <= 1'b1; // R10
      end
      else if (wr_wrapl)
      begin
         wrap_value   <= {wrap_pending ? wrap_high_hold : wrap_value[15:8], wdata_i};
         wrap_pending <= 1'b0; // R10
      end
   end

   // Low-byte latch for coherent counter reads.
   always @(posedge clk_i or negedge rst_n_i)
   begin
      if (!rst_n_i)
      begin
         low_latch   <= 8'h00;
         low_latched <= 1'b0;
      end
      else if (rd_cnth && !low_latched)
      begin
         low_latch   <= count[7:0]; // R09
         low_latched <= 1'b1;
      end
      else if (rd_cntl)
         low_latched <= 1'b0; // R09
   end

   // Two-flop synchroniser, then an edge history stage.
   always @(posedge clk_i or negedge rst_n_i)
   begin
      if (!rst_n_i)
      begin
         pin_meta <= 2'b00;
         pin_sync <= 2'b00;
         pin_prev <= 2'b00;
      end
      else
      begin
         pin_meta <= chan_pin_i;
         pin_sync <= pin_meta;
         pin_prev <= pin_sync;
      end
   end

   // Per-channel logic.
   genvar g;
   generate
      for (g = 0; g < 2; g = g + 1)
      begin : chan
         wire [1:0] els    = {edge_level_high[g], edge_level_low[g]};
         wire       buf_on = (g == 0) ? channel0_buffered_select : 1'b0; // R21
         wire       live   = (g == 0) || !channel0_buffered_select;        // R15
         wire       capt   = live && !buf_on && !unbuffered_mode_select[g] && (els != 2'b00);
         wire       cmp    = live && (buf_on || unbuffered_mode_select[g]);
         wire       rise   = pin_sync[g] && !pin_prev[g];
         wire       fall   = !pin_sync[g] && pin_prev[g];
         wire       edge_hit = (els[0] && rise) || (els[1] && fall); // R18
         wire [15:0] cval  = (g == 0) ? CH0_VALUE : CH1_VALUE;
         wire       match  = cmp && tick && (count == cval);
         wire       ev     = (capt && !counter_halt && edge_hit) || match; // R05 R12
         wire       tov_hit = cmp && overflow_toggle_enable[g] && ovf_event;
         wire       drive  = live && (els != 2'b00); // R17

         // Channel status and control register with two-step flag clear.
         always @(posedge clk_i or negedge rst_n_i)
         begin
            if (!rst_n_i)
            begin
               channel_event_flag[g]     <= 1'b0;
               channel_irq_enable[g]     <= 1'b0;
               unbuffered_mode_select[g] <= 1'b0;
               edge_level_high[g]        <= 1'b0;
               edge_level_low[g]         <= 1'b0;
               overflow_toggle_enable[g] <= 1'b0;
               full_duty_force[g]        <= 1'b0;
               chan_armed[g]             <= 1'b0;
            end
            else
            begin
               if (ev)
               begin
                  channel_event_flag[g] <= 1'b1; // R12
                  chan_armed[g]         <= 1'b0;
               end
               else if (wr_csc[g] && chan_armed[g] && !wdata_i[`TCR_CS_FLAG])
               begin
                  channel_event_flag[g] <= 1'b0; // R13
                  chan_armed[g]         <= 1'b0;
               end
               else if (rd_csc[g] && channel_event_flag[g])
                  chan_armed[g] <= 1'b1;
               if (wr_csc[g])
               begin
                  channel_irq_enable[g]     <= wdata_i[`TCR_CS_IE];
                  unbuffered_mode_select[g] <= wdata_i[`TCR_CS_UNBUF];
                  edge_level_high[g]        <= wdata_i[`TCR_CS_ELH];
                  edge_level_low[g]         <= wdata_i[`TCR_CS_ELL];
                  overflow_toggle_enable[g] <= wdata_i[`TCR_CS_TOV];
                  full_duty_force[g]        <= wdata_i[`TCR_CS_MAX];
               end
            end
         end

         // Pin level: preset, overflow toggle, compare action and full duty.
         always @(posedge clk_i or negedge rst_n_i)
         begin
            if (!rst_n_i)
            begin
               pin_level[g]        <= 1'b1;
               full_duty_active[g] <= 1'b0;
            end
            else if (els == 2'b00)
               pin_level[g] <= !unbuffered_mode_select[g]; // R16
            else if (cmp)
            begin
               if (ovf_event)
                  full_duty_active[g] <= full_duty_force[g] && overflow_toggle_enable[g]; // R23
               if (full_duty_active[g] && overflow_toggle_enable[g])
                  pin_level[g] <= !els[0]; // R23
               else if (tov_hit)
                  pin_level[g] <= !pin_level[g]; // R22
               else if (match)
               begin
                  case (els) // R19
                     2'b01:   pin_level[g] <= !pin_level[g];
                     2'b10:   pin_level[g] <= 1'b0;
                     2'b11:   pin_level[g] <= 1'b1;
                     default: pin_level[g] <= pin_level[g];
                  endcase
               end
            end
         end

         // Registered pin and interrupt outputs.
         always @(posedge clk_i or negedge rst_n_i)
         begin
            if (!rst_n_i)
            begin
               chan_pin_o[g]    <= 1'b0;
               chan_pin_oe_o[g] <= 1'b0;
               chan_irq_o[g]    <= 1'b0;
            end
            else
            begin
               chan_pin_o[g]    <= pin_level[g];
               chan_pin_oe_o[g] <= drive && cmp; // R17
               chan_irq_o[g]    <= channel_event_flag[g] && channel_irq_enable[g]; // R14 R24
            end
         end
      end
   endgenerate

   // Channel 0 buffered bit is only in channel 0's register.
   always @(posedge clk_i or negedge rst_n_i)
   begin
      if (!rst_n_i)
         channel0_buffered_select <= 1'b0;
      else if (wr_csc[0])
         channel0_buffered_select <= wdata_i[`TCR_CS_BUF]; // R15
   end

   // Overflow interrupt and read data, both registered.
   always @(posedge clk_i or negedge rst_n_i)
   begin
      if (!rst_n_i)
      begin
         ovf_irq_o <= 1'b0;
         rdata_o   <= 8'h00;
      end
      else
      begin
         ovf_irq_o <= overflow_flag && overflow_irq_enable; // R03 R24
         if (rd_i)
         begin
            case (addr_i)
               `TCR_ADDR_TSTAT: rdata_o <= {overflow_flag, overflow_irq_enable, counter_halt, 2'b00,
                                            prescale_select}; // R06
               `TCR_ADDR_CNTH:  rdata_o <= count[15:8];
               `TCR_ADDR_CNTL:  rdata_o <= low_latched ? low_latch : count[7:0];
               `TCR_ADDR_WRAPH: rdata_o <= wrap_value[15:8];
               `TCR_ADDR_WRAPL: rdata_o <= wrap_value[7:0];
               `TCR_ADDR_CH0SC: rdata_o <= {channel_event_flag[0], channel_irq_enable[0],
                                            channel0_buffered_select, unbuffered_mode_select[0],
                                            edge_level_high[0], edge_level_low[0],
                                            overflow_toggle_enable[0], full_duty_force[0]};
               `TCR_ADDR_CH1SC: rdata_o <= channel0_buffered_select ? 8'h00 :
                                           {channel_event_flag[1], channel_irq_enable[1], 1'b0,
                                            unbuffered_mode_select[1], edge_level_high[1],
                                            edge_level_low[1], overflow_toggle_enable[1],
                                            full_duty_force[1]};
               default:         rdata_o <= 8'h00;
            endcase
         end
         else
            rdata_o <= 8'h00;
      end
   end

endmodule

// >>> tcr_checker.sv
/*
 Port checker for the two-channel timer: shadows the control bits written by software.
 Assumes it is bound to every tcr_timer instance and sees only that module's ports.
*/
`include "tcr_consts.vh"
module tcr_checker (
   // Clock, reset and register port.
   input wire       clk_i,
   input wire       rst_n_i,
   input wire [2:0] addr_i,
   input wire [7:0] wdata_i,
   input wire       wr_i,
   input wire       rd_i,
   input wire [7:0] rdata_o,
   // Pins and interrupt requests.
   input wire [1:0] chan_pin_oe_o,
   input wire       ovf_irq_o,
   input wire [1:0] chan_irq_o
);
   timeunit 1ns;
   timeprecision 100ps;
   reg       sh_ovie;
   reg       sh_ie0;
   reg       sh_buf;
   reg [1:0] sh_el0;

   // Shadow copies of enable, buffered and edge bits, updated as the design takes each write.
   always @(posedge clk_i or negedge rst_n_i)
   begin
      if (!rst_n_i)
      begin
         sh_ovie <= 1'b0;
         sh_ie0  <= 1'b0;
         sh_buf  <= 1'b0;
         sh_el0  <= 2'b00;
      end
      else if (wr_i && addr_i == `TCR_ADDR_TSTAT)
         sh_ovie <= wdata_i[`TCR_TS_OVIE];
      else if (wr_i && addr_i == `TCR_ADDR_CH0SC)
      begin
         sh_ie0 <= wdata_i[`TCR_CS_IE];
         sh_buf <= wdata_i[`TCR_CS_BUF];
         sh_el0 <= wdata_i[`TCR_CS_ELH:`TCR_CS_ELL];
      end
   end

   default clocking cb @(posedge clk_i); endclocking
   default disable iff (!rst_n_i);

   // The clear bit of the status register never reads back as one.
   property p_clear_reads_zero;
      rd_i && addr_i == `TCR_ADDR_TSTAT |=> !rdata_o[`TCR_TS_CLR];
   endproperty
   a_clear_reads_zero: assert property (p_clear_reads_zero)
      else $error("status read shows the clear bit set");
   // An overflow request needs the overflow enable.
   property p_ovf_irq_off;
      !sh_ovie && !$past(sh_ovie) |-> !ovf_irq_o;
   endproperty
   a_ovf_irq_off: assert property (p_ovf_irq_off)
      else $error("overflow request while its enable is off");
   // The overflow request only drops after a status write.
   property p_ovf_irq_fall;
      $fell(ovf_irq_o) |-> $past(wr_i && addr_i == `TCR_ADDR_TSTAT) || $past(wr_i && addr_i == `TCR_ADDR_TSTAT, 2);
   endproperty
   a_ovf_irq_fall: assert property (p_ovf_irq_fall)
      else $error("overflow request dropped with no status write");
   // A channel request needs the channel enable.
   property p_ch_irq_off;
      !sh_ie0 && !$past(sh_ie0) |-> !chan_irq_o[0];
   endproperty
   a_ch_irq_off: assert property (p_ch_irq_off)
      else $error("channel 0 request while its enable is off");
   // The channel request only drops after a channel write.
   property p_ch_irq_fall;
      $fell(chan_irq_o[0]) |-> $past(wr_i && addr_i == `TCR_ADDR_CH0SC) || $past(wr_i && addr_i == `TCR_ADDR_CH0SC, 2);
   endproperty
   a_ch_irq_fall: assert property (p_ch_irq_fall)
      else $error("channel 0 request dropped with no channel write");
   // Edge bits zero leave the pin to the port.
   property p_pin_released;
      sh_el0 == 2'b00 && $past(sh_el0) == 2'b00 |-> !chan_pin_oe_o[0];
   endproperty
   a_pin_released: assert property (p_pin_released)
      else $error("channel 0 drives its pin with edge bits zero");
   // Buffered mode hands the channel 1 pin back to the port.
   property p_ch1_freed;
      sh_buf && $past(sh_buf) |-> !chan_pin_oe_o[1];
   endproperty
   a_ch1_freed: assert property (p_ch1_freed)
      else $error("channel 1 drives its pin in buffered mode");
   // Buffered mode disables the channel 1 register.
   property p_ch1_reads_zero;
      rd_i && addr_i == `TCR_ADDR_CH1SC && sh_buf && $past(sh_buf) |=> rdata_o == 8'h00;
   endproperty
   a_ch1_reads_zero: assert property (p_ch1_reads_zero)
      else $error("channel 1 register visible in buffered mode");
endmodule
bind tcr_timer tcr_checker chk_u (.clk_i(clk_i), .rst_n_i(rst_n_i), .addr_i(addr_i), .wdata_i(wdata_i),
   .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o), .chan_pin_oe_o(chan_pin_oe_o), .ovf_irq_o(ovf_irq_o),
   .chan_irq_o(chan_irq_o));

// >>> tcr_pin_model.sv
/*
 Far side of the channel pins: a driver that the design can override.
 Assumes the bench sets the outside level and feeds the result to the pin inputs.
*/
module tcr_pin_model (
   // Outside level and design drive.
   input  wire [1:0] drive_i,
   input  wire [1:0] dut_out_i,
   input  wire [1:0] dut_oe_i,
   // Resolved pin level.
   output wire [1:0] level_o
);
   timeunit 1ns;
   timeprecision 100ps;
   // A pin the design drives shows its level; a released pin shows the outside level.
   assign level_o = (dut_oe_i & dut_out_i) | (~dut_oe_i & drive_i);
endmodule

// >>> two_channel_timer_registers_test.sv
/*
 Testbench for the two-channel timer: register tasks and sequences with expected values.
 Assumes one 250 MHz clock and the pin model on the channel pins.
*/
`include "tcr_consts.vh"
module two_channel_timer_registers_test;
   timeunit 1ns;
   timeprecision 100ps;
   logic       clk_i = 1'b0;
   logic       rst_n_i = 1'b0;
   logic [2:0] addr_i = 3'h0;
   logic [7:0] wdata_i = 8'h00;
   logic       wr_i = 1'b0;
   logic       rd_i = 1'b0;
   logic [1:0] ext = 2'b00;
   wire  [7:0] rdata_o;
   wire  [1:0] pin_in, pin_out, pin_oe, chan_irq_o;
   wire        ovf_irq_o;
   logic [7:0] d, lx, ly;
   logic       p;
   int         i, j, mismatches = 0, samples_checked = 0;

   // The clock toggles every half period of 2 ns.
   always #2 clk_i = ~clk_i;

   tcr_timer #(.CH0_VALUE(16'h0005), .CH1_VALUE(16'h0005)) dut_u (.clk_i(clk_i), .rst_n_i(rst_n_i),
      .addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o), .chan_pin_i(pin_in),
      .chan_pin_o(pin_out), .chan_pin_oe_o(pin_oe), .ovf_irq_o(ovf_irq_o), .chan_irq_o(chan_irq_o));
   tcr_pin_model pin_u (.drive_i(ext), .dut_out_i(pin_out), .dut_oe_i(pin_oe), .level_o(pin_in));

   // Register write: one strobe cycle.
   task wr(input logic [2:0] a, input logic [7:0] v);
      @(posedge clk_i);
      addr_i <= a;
      wdata_i <= v;
      wr_i <= 1'b1;
      @(posedge clk_i);
      wr_i <= 1'b0;
   endtask
   // Register read: data are sampled in the cycle after the strobe.
   task rd(input logic [2:0] a, output logic [7:0] v);
      @(posedge clk_i);
      addr_i <= a;
      rd_i <= 1'b1;
      @(posedge clk_i);
      rd_i <= 1'b0;
      #1 v = rdata_o;
   endtask
   task chk(input logic [7:0] got, input logic [7:0] exp);
      samples_checked++;
      if (got !== exp)
      begin
         $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
         mismatches++;
      end
   endtask
   task complete_run;
      $display("checks %0d mismatches %0d", samples_checked, mismatches);
      if (mismatches == 0 && samples_checked > 0)
         $display("Test passed");
      else
         $display("Test failed");
      $finish;
   endtask

   // Main sequence.
   initial
   begin
      repeat (3) @(posedge clk_i);
      rst_n_i <= 1'b1;
      rd(`TCR_ADDR_TSTAT, d);
      chk(d, `TCR_TSTAT_RST);
      rd(`TCR_ADDR_WRAPL, d);
      chk(d, 8'hFF);
      for (i = 1; i < 8; i++)
         if (i != 3 && i != 4)
         begin
            rd(i[2:0], d);
            chk(d, 8'h00);
         end
      $display("reset test done");
      // Each prescale code up to 110 runs for 32 ticks of its divided clock, then halts; code 111 never ticks and must read zero.
      for (i = 0; i < 8; i++)
      begin
         wr(`TCR_ADDR_TSTAT, {5'b00110, i[2:0]});
         rd(`TCR_ADDR_CNTL, d);
         chk(d, 8'h00);
         wr(`TCR_ADDR_TSTAT, {5'b00000, i[2:0]});
         repeat (32 << i) @(posedge clk_i);
         wr(`TCR_ADDR_TSTAT, {5'b00100, i[2:0]});
         rd(`TCR_ADDR_CNTL, d);
         if (i == 7)
            chk(d, 8'h00);
         else
            chk({7'h00, d >= 8'd30 && d <= 8'd38}, 8'h01);
         repeat (20) @(posedge clk_i);
         rd(`TCR_ADDR_CNTL, lx);
         chk(lx, d);
      end
      // A high read holds the low byte through a later high read.
      wr(`TCR_ADDR_TSTAT, 8'h10);
      rd(`TCR_ADDR_CNTH, d);
      repeat (50) @(posedge clk_i);
      rd(`TCR_ADDR_CNTH, d);
      rd(`TCR_ADDR_CNTL, lx);
      rd(`TCR_ADDR_CNTL, ly);
      chk({7'h00, (ly - lx) > 8'd40}, 8'h01);
      $display("counter test done");
      // Wrap high alone holds off the flag; the low byte re-arms it.
      wr(`TCR_ADDR_TSTAT, 8'h30);
      wr(`TCR_ADDR_WRAPH, 8'h00);
      wr(`TCR_ADDR_WRAPL, 8'h09);
      wr(`TCR_ADDR_WRAPH, 8'h00);
      wr(`TCR_ADDR_TSTAT, 8'h40);
      repeat (300) @(posedge clk_i);
      rd(`TCR_ADDR_TSTAT, d);
      chk(d, 8'h40);
      wr(`TCR_ADDR_WRAPL, 8'h09);
      for (i = 0; i < 40 && ovf_irq_o !== 1'b1; i++)
         @(posedge clk_i);
      chk({7'h00, ovf_irq_o}, 8'h01);
      if (i == 40)
         complete_run();
      for (i = 0; i < 6; i++)
      begin
         rd(`TCR_ADDR_CNTL, d);
         chk({7'h00, d <= 8'h09}, 8'h01);
      end
      wr(`TCR_ADDR_TSTAT, 8'h60);
      rd(`TCR_ADDR_TSTAT, d);
      chk(d, 8'hE0);
      wr(`TCR_ADDR_TSTAT, 8'h60);
      rd(`TCR_ADDR_TSTAT, d);
      chk(d, 8'h60);
      chk({7'h00, ovf_irq_o}, 8'h00);
      wr(`TCR_ADDR_TSTAT, 8'hE0);
      rd(`TCR_ADDR_TSTAT, d);
      chk(d, 8'h60);
      $display("overflow test done");
      // Every capture code against a rising and a falling edge.
      for (i = 1; i < 4; i++)
         for (j = 0; j < 2; j++)
         begin
            ext[0] <= ~j[0];
            wr(`TCR_ADDR_TSTAT, 8'h30);
            rd(`TCR_ADDR_CH0SC, d);
            wr(`TCR_ADDR_CH0SC, {4'h4, i[1:0], 2'b00});
            wr(`TCR_ADDR_TSTAT, 8'h00);
            repeat (8) @(posedge clk_i);
            ext[0] <= j[0];
            repeat (8) @(posedge clk_i);
            p = j ? i[0] : i[1];
            rd(`TCR_ADDR_CH0SC, d);
            chk(d, {p, 3'b100, i[1:0], 2'b00});
            chk({7'h00, chan_irq_o[0]}, {7'h00, p});
         end
      // A halted counter ignores capture edges.
      wr(`TCR_ADDR_TSTAT, 8'h30);
      rd(`TCR_ADDR_CH0SC, d);
      wr(`TCR_ADDR_CH0SC, 8'h0C);
      ext[0] <= ~ext[0];
      repeat (8) @(posedge clk_i);
      rd(`TCR_ADDR_CH0SC, d);
      chk(d, 8'h0C);
      $display("capture test done");
      // Every unbuffered compare code against a match at count 5 of 10.
      for (i = 0; i < 4; i++)
      begin
         wr(`TCR_ADDR_TSTAT, 8'h30);
         rd(`TCR_ADDR_CH0SC, d);
         wr(`TCR_ADDR_CH0SC, {4'h1, i[1:0], 2'b00});
         wr(`TCR_ADDR_TSTAT, 8'h00);
         repeat (30) @(posedge clk_i);
         rd(`TCR_ADDR_CH0SC, d);
         chk(d, {4'h9, i[1:0], 2'b00});
         chk({7'h00, pin_oe[0]}, {7'h00, i != 0});
         p = pin_out[0];
         if (i == 0)
            chk({7'h00, pin_out[0]}, 8'h00);
         repeat (10) @(posedge clk_i);
         #1;
         if (i == 1)
            chk({7'h00, pin_out[0]}, {7'h00, ~p});
         if (i > 1)
            chk({7'h00, pin_out[0]}, {7'h00, i[0]});
      end
      // Toggle on overflow with the full-duty bit keeps a clear-on-match pin high.
      wr(`TCR_ADDR_TSTAT, 8'h30);
      wr(`TCR_ADDR_CH0SC, 8'h1B);
      wr(`TCR_ADDR_TSTAT, 8'h00);
      repeat (30) @(posedge clk_i);
      for (j = 0; j < 3; j++)
      begin
         repeat (3) @(posedge clk_i);
         #1 chk({7'h00, pin_out[0]}, 8'h01);
      end
      // Channel 1 captures on its own, then buffered mode takes it away.
      wr(`TCR_ADDR_TSTAT, 8'h30);
      wr(`TCR_ADDR_CH0SC, 8'h00);
      wr(`TCR_ADDR_CH1SC, 8'h04);
      wr(`TCR_ADDR_TSTAT, 8'h00);
      ext[1] <= 1'b1;
      repeat (8) @(posedge clk_i);
      rd(`TCR_ADDR_CH1SC, d);
      chk(d, 8'h84);
      wr(`TCR_ADDR_CH0SC, 8'h20);
      rd(`TCR_ADDR_CH1SC, d);
      chk(d, 8'h00);
      rd(`TCR_ADDR_CH0SC, d);
      chk(d, 8'hA0);
      $display("channel test done");
      complete_run();
   end
endmodule
